// ===== trpv_pkg.sv
// Constants, register map and carriers for the trap priority and vector unit
package trpv_pkg;
  localparam int          NUM_CLASS   = 34;
  localparam int          TT_W        = 9;
  localparam int          TL_W        = 3;
  localparam logic [2:0]  MAX_PTL     = 3'h2;
  localparam logic [8:0]  HW_TT_MASK  = 9'h0ff;
  localparam logic [8:0]  SW_TT_BASE  = 9'h100;
  localparam logic [8:0]  SPILL_BASE  = 9'h080;
  localparam logic [8:0]  FILL_BASE   = 9'h0c0;
  localparam logic [4:0]  VEC_LOW     = 5'h00;
  // Register byte offsets
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_MASKLVL   = 8'h04;
  localparam logic [7:0]  A_FPSTAT    = 8'h08;
  localparam logic [7:0]  A_TBA_LO    = 8'h0c;
  localparam logic [7:0]  A_TBA_HI    = 8'h10;
  localparam logic [7:0]  A_HTBA_LO   = 8'h14;
  localparam logic [7:0]  A_HTBA_HI   = 8'h18;
  localparam logic [7:0]  A_TL        = 8'h1c;
  localparam logic [7:0]  A_TT        = 8'h20;
  localparam logic [7:0]  A_WIN       = 8'h24;
  localparam logic [7:0]  A_VEC_LO    = 8'h28;
  localparam logic [7:0]  A_VEC_HI    = 8'h2c;
  localparam logic [7:0]  A_STATUS    = 8'h30;
  // Control register fields
  localparam int          CTL_IE      = 0;
  localparam int          CTL_TLE     = 1;
  localparam int          CTL_PRIV    = 2;
  localparam int          CTL_HPRIV   = 3;
  localparam logic [3:0]  CTRL_RST    = 4'h4;
  // Floating-point status fields
  localparam int          FP_TEM_LSB  = 0;
  localparam int          FP_AEXC_LSB = 5;
  localparam int          FP_FCC_LSB  = 10;
  // Window register fields
  localparam int          WIN_OW_LSB  = 0;
  localparam int          WIN_WN_LSB  = 3;
  localparam int          WIN_WO_LSB  = 6;
  // Status register fields
  localparam int          ST_HYP      = 9;
  localparam int          ST_FPP      = 10;

  typedef logic [TT_W-1:0] trpv_tt_t;

  // Result of one taken trap
  typedef struct packed {
    logic        hyper;
    logic        endian;
    trpv_tt_t    tt;
    logic [63:0] vec;
  } trpv_trap_s;

  // One floating-point result report
  typedef struct packed {
    logic       valid;
    logic [4:0] flags;
    logic [7:0] fcc;
  } trpv_fp_s;
endpackage

// ===== trpv_top.sv
// Trap priority selection, masking and vector formation with APB registers
`timescale 1ns/1ps
`default_nettype none
module trpv_top #(
  parameter int                CLS_INT     = 32,
  parameter int                CLS_WIN     = 9,
  parameter int                CLS_FP      = 11,
  parameter int                CLS_TCC     = 16,
  parameter trpv_pkg::trpv_tt_t FP_TT      = 9'h030,
  parameter trpv_pkg::trpv_tt_t INT_TT_BASE = 9'h040
) (
  input  wire logic                                 CORE_CLK,
  input  wire logic                                 RST_B,
  input  wire logic                                 PSEL,
  input  wire logic                                 PENABLE,
  input  wire logic                                 PWRITE,
  input  wire logic [7:0]                           PADDR,
  input  wire logic [31:0]                          PWDATA,
  output logic      [31:0]                          PRDATA,
  output logic                                      PREADY,
  output logic                                      PSLVERR,
  input  wire logic                                 INSN_BOUNDARY,
  input  wire logic [trpv_pkg::NUM_CLASS-1:0]       EXC_REQ,
  input  wire trpv_pkg::trpv_tt_t [trpv_pkg::NUM_CLASS-1:0] EXC_TT,
  input  wire logic [trpv_pkg::NUM_CLASS-1:0]       EXC_HYPER,
  input  wire logic [trpv_pkg::NUM_CLASS-1:0]       EXC_DISRUPT,
  input  wire logic [15:0]                          INT_REQ,
  input  wire logic                                 SPILL_REQ,
  input  wire logic                                 FILL_REQ,
  input  wire logic                                 TCC_REQ,
  input  wire logic [6:0]                           TCC_NUM,
  input  wire trpv_pkg::trpv_fp_s                   FP_IN,
  output logic                                      TRAP_TAKE,
  output trpv_pkg::trpv_trap_s                      TRAP_INFO,
  output logic                                      FP_DEST_WE
);
  localparam int NTL = 1 << trpv_pkg::TL_W;

  // Software-visible state and registered bus and trap outputs
  logic [3:0]                ctrl_q;
  logic [3:0]                mlvl_q;
  logic [4:0]                tem_q;
  logic [4:0]                aexc_q;
  logic [7:0]                fcc_q;
  logic [63:0]               tba_q;
  logic [63:0]               htba_q;
  logic [trpv_pkg::TL_W-1:0] tl_q;
  trpv_pkg::trpv_tt_t        tt_q [NTL];
  logic [2:0]                ow_q;
  logic [2:0]                wsn_q;
  logic [2:0]                wso_q;
  logic                      fpp_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic [31:0]               prdata_q;
  logic                      take_q;
  logic                      fpwe_q;
  trpv_pkg::trpv_trap_s      info_q;

  // Bus decode
  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd_word;
  assign acc = PSEL & PENABLE & ~pready_q;
  assign wr  = PSEL & PENABLE & PWRITE & pready_q;
  assign hit = (PADDR == trpv_pkg::A_CTRL)    | (PADDR == trpv_pkg::A_MASKLVL) |
               (PADDR == trpv_pkg::A_FPSTAT)  | (PADDR == trpv_pkg::A_TBA_LO)  |
               (PADDR == trpv_pkg::A_TBA_HI)  | (PADDR == trpv_pkg::A_HTBA_LO) |
               (PADDR == trpv_pkg::A_HTBA_HI) | (PADDR == trpv_pkg::A_TL)      |
               (PADDR == trpv_pkg::A_TT)      | (PADDR == trpv_pkg::A_WIN)     |
               (PADDR == trpv_pkg::A_VEC_LO)  | (PADDR == trpv_pkg::A_VEC_HI)  |
               (PADDR == trpv_pkg::A_STATUS);

  // Register write strobes
  logic w_ctrl, w_mlvl, w_fp, w_tbal, w_tbah, w_htl, w_hth, w_tl, w_tt, w_win;
  assign w_ctrl = wr & (PADDR == trpv_pkg::A_CTRL);
  assign w_mlvl = wr & (PADDR == trpv_pkg::A_MASKLVL);
  assign w_fp   = wr & (PADDR == trpv_pkg::A_FPSTAT);
  assign w_tbal = wr & (PADDR == trpv_pkg::A_TBA_LO);
  assign w_tbah = wr & (PADDR == trpv_pkg::A_TBA_HI);
  assign w_htl  = wr & (PADDR == trpv_pkg::A_HTBA_LO);
  assign w_hth  = wr & (PADDR == trpv_pkg::A_HTBA_HI);
  assign w_tl   = wr & (PADDR == trpv_pkg::A_TL);
  assign w_tt   = wr & (PADDR == trpv_pkg::A_TT);
  assign w_win  = wr & (PADDR == trpv_pkg::A_WIN);

  // Floating-point exception gating
  logic [4:0] fp_en;
  logic       fp_hit;
  logic       fp_acc;
  assign fp_en  = FP_IN.flags & tem_q;
  assign fp_hit = FP_IN.valid & (|fp_en);
  assign fp_acc = FP_IN.valid & ~(|fp_en);

  // Disrupting delivery conditions
  logic priv_ok;
  assign priv_ok = ctrl_q[trpv_pkg::CTL_IE] & (tl_q < trpv_pkg::MAX_PTL);

  // Highest pending interrupt level above the mask
  logic [3:0] int_lvl;
  logic       int_ok;
  always_comb begin
    int_lvl = 4'h0;
    for (int l = 1; l < 16; l++) begin
      if (INT_REQ[l] && (4'(l) > mlvl_q)) begin
        int_lvl = 4'(l);
      end
    end
  end
  assign int_ok = (int_lvl != 4'h0) & priv_ok;

  // Spill and fill trap types from the window registers
  logic [2:0]         win_sel;
  trpv_pkg::trpv_tt_t win_tt;
  assign win_sel = (ow_q != 3'h0) ? wso_q : wsn_q;
  assign win_tt  = (SPILL_REQ ? trpv_pkg::SPILL_BASE : trpv_pkg::FILL_BASE) |
                   {3'h0, (ow_q != 3'h0), win_sel, 2'h0};

  // Candidate per priority class; fixed source order inside a class
  logic [trpv_pkg::NUM_CLASS-1:0] cand;
  trpv_pkg::trpv_tt_t             cand_tt  [trpv_pkg::NUM_CLASS];
  logic [trpv_pkg::NUM_CLASS-1:0] cand_hyp;
  always_comb begin
    for (int c = 0; c < trpv_pkg::NUM_CLASS; c++) begin
      cand[c]     = EXC_REQ[c] & (~EXC_DISRUPT[c] | EXC_HYPER[c] | priv_ok);
      cand_tt[c]  = EXC_TT[c] & trpv_pkg::HW_TT_MASK;
      cand_hyp[c] = EXC_HYPER[c];
      if (!cand[c]) begin
        if (c == CLS_INT && int_ok) begin
          cand[c]     = 1'b1;
          cand_tt[c]  = INT_TT_BASE + {5'h0, int_lvl};
          cand_hyp[c] = 1'b0;
        end else if (c == CLS_WIN && (SPILL_REQ || FILL_REQ)) begin
          cand[c]     = 1'b1;
          cand_tt[c]  = win_tt;
          cand_hyp[c] = 1'b0;
        end else if (c == CLS_FP && fpp_q) begin
          cand[c]     = 1'b1;
          cand_tt[c]  = FP_TT & trpv_pkg::HW_TT_MASK;
          cand_hyp[c] = 1'b0;
        end else if (c == CLS_TCC && TCC_REQ) begin
          cand[c]     = 1'b1;
          cand_tt[c]  = trpv_pkg::SW_TT_BASE | {2'h0, TCC_NUM};
          cand_hyp[c] = 1'b0;
        end
      end
    end
  end

  // Lowest class number wins
  logic               any_sel;
  trpv_pkg::trpv_tt_t sel_tt;
  logic               sel_hyp;
  logic               sel_fp;
  always_comb begin
    any_sel = 1'b0;
    sel_tt  = '0;
    sel_hyp = 1'b0;
    sel_fp  = 1'b0;
    for (int c = trpv_pkg::NUM_CLASS - 1; c >= 0; c--) begin
      if (cand[c]) begin
        any_sel = 1'b1;
        sel_tt  = cand_tt[c];
        sel_hyp = cand_hyp[c];
        sel_fp  = (c == CLS_FP) & ~EXC_REQ[c];
      end
    end
  end

  // Delivery mode and vector formation
  logic                      take;
  logic                      deliv_hyp;
  logic [63:0]               base;
  logic [63:0]               vec;
  logic [trpv_pkg::TL_W-1:0] tl_nxt;
  assign take      = INSN_BOUNDARY & any_sel;
  assign deliv_hyp = sel_hyp | ctrl_q[trpv_pkg::CTL_HPRIV] |
                     (tl_q >= trpv_pkg::MAX_PTL);
  assign base      = deliv_hyp ? htba_q : tba_q;
  assign vec       = {base[63:15],
                      (tl_q != '0),
                      sel_tt,
                      trpv_pkg::VEC_LOW};
  assign tl_nxt    = (tl_q == '1) ? tl_q : tl_q + 1'b1;

  // Read data selection
  assign rd_word =
    (PADDR == trpv_pkg::A_CTRL)    ? {28'h0, ctrl_q} :
    (PADDR == trpv_pkg::A_MASKLVL) ? {28'h0, mlvl_q} :
    (PADDR == trpv_pkg::A_FPSTAT)  ? {14'h0, fcc_q, aexc_q, tem_q} :
    (PADDR == trpv_pkg::A_TBA_LO)  ? tba_q[31:0] :
    (PADDR == trpv_pkg::A_TBA_HI)  ? tba_q[63:32] :
    (PADDR == trpv_pkg::A_HTBA_LO) ? htba_q[31:0] :
    (PADDR == trpv_pkg::A_HTBA_HI) ? htba_q[63:32] :
    (PADDR == trpv_pkg::A_TL)      ? {29'h0, tl_q} :
    (PADDR == trpv_pkg::A_TT)      ? {23'h0, tt_q[tl_q]} :
    (PADDR == trpv_pkg::A_WIN)     ? {23'h0, wso_q, wsn_q, ow_q} :
    (PADDR == trpv_pkg::A_VEC_LO)  ? info_q.vec[31:0] :
    (PADDR == trpv_pkg::A_VEC_HI)  ? info_q.vec[63:32] :
    (PADDR == trpv_pkg::A_STATUS)  ? {21'h0, fpp_q, info_q.hyper, info_q.tt} :
                                     32'h0;

  // Next values with hardware events applied over software writes, accrued flags ORed into the written value
  logic [3:0] ctrl_d;
  logic [4:0] aexc_d;
  logic [7:0] fcc_d;
  logic       fpp_d;
  always_comb begin
    ctrl_d = w_ctrl ? PWDATA[3:0] : ctrl_q;
    if (take) begin
      ctrl_d[trpv_pkg::CTL_IE]    = 1'b0;
      ctrl_d[trpv_pkg::CTL_PRIV]  = 1'b1;
      ctrl_d[trpv_pkg::CTL_HPRIV] = deliv_hyp;
    end
    aexc_d = w_fp ? PWDATA[trpv_pkg::FP_AEXC_LSB +: 5] : aexc_q;
    fcc_d  = w_fp ? PWDATA[trpv_pkg::FP_FCC_LSB +: 8] : fcc_q;
    if (fp_acc) begin
      aexc_d = aexc_d | FP_IN.flags;
      fcc_d  = FP_IN.fcc;
    end
    fpp_d = fp_hit | (fpp_q & ~(take & sel_fp));
  end

  // Bus slave answer, one wait state
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & ~hit;
      prdata_q  <= (acc & ~PWRITE) ? rd_word : 32'h0;
    end
  end

  // Control and status registers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= trpv_pkg::CTRL_RST;
      mlvl_q <= 4'h0;
      tem_q  <= 5'h00;
      aexc_q <= 5'h00;
      fcc_q  <= 8'h00;
      fpp_q  <= 1'b0;
      ow_q   <= 3'h0;
      wsn_q  <= 3'h0;
      wso_q  <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mlvl_q <= w_mlvl ? PWDATA[3:0] : mlvl_q;
      tem_q  <= w_fp ? PWDATA[trpv_pkg::FP_TEM_LSB +: 5] : tem_q;
      aexc_q <= aexc_d;
      fcc_q  <= fcc_d;
      fpp_q  <= fpp_d;
      ow_q   <= w_win ? PWDATA[trpv_pkg::WIN_OW_LSB +: 3] : ow_q;
      wsn_q  <= w_win ? PWDATA[trpv_pkg::WIN_WN_LSB +: 3] : wsn_q;
      wso_q  <= w_win ? PWDATA[trpv_pkg::WIN_WO_LSB +: 3] : wso_q;
    end
  end

  // Trap base registers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tba_q  <= 64'h0;
      htba_q <= 64'h0;
    end else begin
      if (w_tbal) tba_q[31:0]   <= PWDATA;
      if (w_tbah) tba_q[63:32]  <= PWDATA;
      if (w_htl)  htba_q[31:0]  <= PWDATA;
      if (w_hth)  htba_q[63:32] <= PWDATA;
    end
  end

  // Nesting level and per-level trap type
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tl_q <= '0;
      for (int i = 0; i < NTL; i++) tt_q[i] <= '0;
    end else if (take) begin
      tl_q         <= tl_nxt;
      tt_q[tl_nxt] <= sel_tt;
    end else begin
      if (w_tl) tl_q <= PWDATA[trpv_pkg::TL_W-1:0];
      if (w_tt) tt_q[tl_q] <= PWDATA[trpv_pkg::TT_W-1:0];
    end
  end

  // Trap and floating-point result outputs
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      take_q <= 1'b0;
      fpwe_q <= 1'b0;
      info_q <= '0;
    end else begin
      take_q <= take;
      fpwe_q <= fp_acc;
      if (take) begin
        info_q.hyper  <= deliv_hyp;
        info_q.endian <= ctrl_q[trpv_pkg::CTL_TLE];
        info_q.tt     <= sel_tt;
        info_q.vec    <= vec;
      end
    end
  end

  assign PRDATA     = prdata_q;
  assign PREADY     = pready_q;
  assign PSLVERR    = pslverr_q;
  assign TRAP_TAKE  = take_q;
  assign TRAP_INFO  = info_q;
  assign FP_DEST_WE = fpwe_q;
endmodule // trpv_top
`default_nettype wire

// ===== trpv_checker.sv
// Port-level assertions for the trap priority and vector unit
`timescale 1ns/1ps
`default_nettype none
module trpv_checker (
  input wire logic                                          CORE_CLK,
  input wire logic                                          RST_B,
  input wire logic                                          PSEL,
  input wire logic                                          PENABLE,
  input wire logic [31:0]                                   PRDATA,
  input wire logic                                          PREADY,
  input wire logic                                          PSLVERR,
  input wire logic                                          INSN_BOUNDARY,
  input wire logic [trpv_pkg::NUM_CLASS-1:0]                EXC_REQ,
  input wire trpv_pkg::trpv_tt_t [trpv_pkg::NUM_CLASS-1:0]  EXC_TT,
  input wire logic [trpv_pkg::NUM_CLASS-1:0]                EXC_HYPER,
  input wire logic [trpv_pkg::NUM_CLASS-1:0]                EXC_DISRUPT,
  input wire trpv_pkg::trpv_fp_s                            FP_IN,
  input wire logic                                          TRAP_TAKE,
  input wire trpv_pkg::trpv_trap_s                          TRAP_INFO,
  input wire logic                                          FP_DEST_WE
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Trap and floating-point result paths
  take_bound_a: assert property (TRAP_TAKE |-> $past(INSN_BOUNDARY))
    else $error("trap taken off a boundary");
  top_class_a: assert property (INSN_BOUNDARY && EXC_REQ[0] && (EXC_HYPER[0] || !EXC_DISRUPT[0]) |=>
    TRAP_TAKE && TRAP_INFO.tt == {1'b0, $past(EXC_TT[0][7:0])}) else $error("class zero not taken");
  hyper_dest_a: assert property (INSN_BOUNDARY && EXC_REQ[0] && EXC_HYPER[0] |=> TRAP_INFO.hyper)
    else $error("hyper class not hyper");
  vec_low_a: assert property (TRAP_TAKE |-> TRAP_INFO.vec[4:0] == 5'h00)
    else $error("vector low bits set");
  vec_type_a: assert property (TRAP_TAKE |-> TRAP_INFO.vec[13:5] == TRAP_INFO.tt)
    else $error("vector type field wrong");
  sw_range_a: assert property (TRAP_TAKE && TRAP_INFO.tt[8] |-> !TRAP_INFO.tt[7])
    else $error("software code out of range");
  info_hold_a: assert property (!TRAP_TAKE |-> $stable(TRAP_INFO))
    else $error("trap info moved without trap");
  fp_write_a: assert property (FP_DEST_WE |-> $past(FP_IN.valid))
    else $error("result write without result");
  // Register bus timing
  apb_ready_a: assert property ($rose(PSEL && PENABLE) |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle after access");
  err_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response malformed");
  idle_zero_a: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
    else $error("read data outside answer");
  // Main scenarios
  hyp_c: cover property (TRAP_TAKE && TRAP_INFO.hyper);
  sw_c: cover property (TRAP_TAKE && TRAP_INFO.tt[8]);
  err_c: cover property (PSLVERR);
  fpw_c: cover property (FP_DEST_WE);
endmodule // trpv_checker

bind trpv_top trpv_checker u_chk (.CORE_CLK, .RST_B, .PSEL, .PENABLE, .PRDATA, .PREADY, .PSLVERR,
  .INSN_BOUNDARY, .EXC_REQ, .EXC_TT, .EXC_HYPER, .EXC_DISRUPT, .FP_IN, .TRAP_TAKE, .TRAP_INFO, .FP_DEST_WE);
`default_nettype wire

// ===== trpv_top_bench.sv
// Self-checking bench for the trap priority and vector unit
`timescale 1ns/1ps
`default_nettype none
module trpv_top_bench;
  localparam trpv_pkg::trpv_tt_t INT_BASE = 9'h040;
  localparam trpv_pkg::trpv_tt_t FP_CODE  = 9'h030;
  logic                     clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, ins = 0;
  logic                     spill = 0, fill = 0, tcc = 0, tle = 0, pready, pslverr, take, fp_we;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0, prdata;
  logic [33:0]              exc_req = '0, exc_hyper = '0, exc_dis = '0, re;
  trpv_pkg::trpv_tt_t [33:0] exc_tt = '0;
  logic [15:0]              int_req = 16'h0;
  logic [6:0]               tcc_num = 7'h00, r7;
  trpv_pkg::trpv_fp_s       fp_in = '0;
  trpv_pkg::trpv_trap_s     info;
  logic [63:0]              trap_base_reg, hba;
  trpv_pkg::trpv_trap_s     trap_q[$];
  logic [33:0]              rd_q[$];
  logic [7:0]               ra[6] = '{8'h00, 8'h04, 8'h08, 8'h1c, 8'h20, 8'h30};
  int                       n_fail = 0, checked = 0, we_n = 0;

  // Clock
  initial forever #12.5 clk = ~clk;

  trpv_top #(.FP_TT(FP_CODE), .INT_TT_BASE(INT_BASE)) dut (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .INSN_BOUNDARY(ins), .EXC_REQ(exc_req), .EXC_TT(exc_tt), .EXC_HYPER(exc_hyper),
    .EXC_DISRUPT(exc_dis), .INT_REQ(int_req), .SPILL_REQ(spill), .FILL_REQ(fill), .TCC_REQ(tcc),
    .TCC_NUM(tcc_num), .FP_IN(fp_in), .TRAP_TAKE(take), .TRAP_INFO(info), .FP_DEST_WE(fp_we));

  // Comparisons
  task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_t(input trpv_pkg::trpv_trap_s e, input trpv_pkg::trpv_trap_s g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD trap_info exp %h got %h", e, g);
    end
  endtask

  // Bus cycle, expectation noted first
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    rd_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {2'b10, e});
  endtask

  // Boundary cycle, then all requests dropped
  task automatic bnd(input logic b);
    ins <= b;
    @(posedge clk);
    ins <= 1'b0;
    exc_req <= '0;
    exc_hyper <= '0;
    exc_dis <= '0;
    int_req <= 16'h0;
    spill <= 1'b0;
    fill <= 1'b0;
    tcc <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic ex(input logic h, input trpv_pkg::trpv_tt_t t, input logic [63:0] b, input logic nz);
    trap_q.push_back(trpv_pkg::trpv_trap_s'({h, tle, t, b[63:15], nz, t, 5'h00}));
  endtask
  task automatic fp(input logic [4:0] f, input logic [7:0] c);
    fp_in <= trpv_pkg::trpv_fp_s'({1'b1, f, c});
    @(posedge clk);
    fp_in <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic finish_test;
    cmp_w("leftover", 32'h0, 32'(trap_q.size() + rd_q.size() + we_n));
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Output watcher takes the oldest note per result
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      re = rd_q.size() > 0 ? rd_q.pop_front() : 34'h3_ffff_ffff;
      cmp_w("pslverr", {31'h0, re[32]}, {31'h0, pslverr});
      if (re[33])
        cmp_w("prdata", re[31:0], prdata);
    end
    if (take === 1'b1) begin
      if (trap_q.size() == 0)
        cmp_w("trap_take", 32'h0, 32'h1);
      else
        cmp_t(trap_q.pop_front(), info);
    end
    if (fp_we === 1'b1) begin
      cmp_w("fp_dest_we", 32'h1, {31'h0, we_n > 0});
      we_n--;
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  // Main sequence
  initial begin
    void'($urandom(76));
    trap_base_reg = {$urandom, $urandom};
    hba = {$urandom, $urandom};
    r7 = 7'($urandom);
    for (int i = 0; i < trpv_pkg::NUM_CLASS; i++)
      exc_tt[i] <= {1'b0, 8'($urandom)};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (ra[i])
      rd(ra[i], i == 0 ? 32'h4 : 32'h0);
    apb(1'b1, 8'h38, 32'hffff_ffff, 34'h1_0000_0000);
    apb(1'b0, 8'h34, 32'h0, 34'h3_0000_0000);
    $display("test registers done");
    wr(trpv_pkg::A_TBA_LO, trap_base_reg[31:0]);
    wr(trpv_pkg::A_TBA_HI, trap_base_reg[63:32]);
    wr(trpv_pkg::A_HTBA_LO, hba[31:0]);
    wr(trpv_pkg::A_HTBA_HI, hba[63:32]);
    wr(trpv_pkg::A_CTRL, 32'h6);
    tle = 1'b1;
    exc_req <= 34'h4000_0020;
    ex(1'b0, exc_tt[5], trap_base_reg, 1'b0);
    bnd(1'b1);
    exc_req <= 34'h5;
    ex(1'b0, exc_tt[0], trap_base_reg, 1'b1);
    bnd(1'b1);
    exc_req <= 34'h100;
    ex(1'b1, exc_tt[8], hba, 1'b1);
    bnd(1'b1);
    rd(trpv_pkg::A_TT, {23'h0, exc_tt[8]});
    rd(trpv_pkg::A_TL, 32'h3);
    rd(trpv_pkg::A_VEC_LO, {hba[31:15], 1'b1, exc_tt[8], 5'h00});
    $display("test vectors done");
    wr(trpv_pkg::A_TL, 32'h0);
    wr(trpv_pkg::A_CTRL, 32'h4);
    tle = 1'b0;
    tcc <= 1'b1;
    tcc_num <= r7;
    ex(1'b0, {2'b10, r7}, trap_base_reg, 1'b0);
    bnd(1'b1);
    $display("test software trap done");
    wr(trpv_pkg::A_TL, 32'h0);
    wr(trpv_pkg::A_CTRL, 32'h5);
    wr(trpv_pkg::A_MASKLVL, 32'h5);
    int_req <= 16'h0020;
    bnd(1'b1);
    int_req <= 16'h0248;
    ex(1'b0, INT_BASE + 9'h009, trap_base_reg, 1'b0);
    bnd(1'b1);
    int_req <= 16'h0400;
    exc_req <= 34'h20_0000;
    exc_dis <= 34'h20_0000;
    bnd(1'b1);
    exc_req <= 34'h10_0000;
    exc_dis <= 34'h10_0000;
    exc_hyper <= 34'h10_0000;
    ex(1'b1, exc_tt[20], hba, 1'b1);
    bnd(1'b1);
    wr(trpv_pkg::A_TL, 32'h2);
    wr(trpv_pkg::A_CTRL, 32'h5);
    int_req <= 16'h8000;
    bnd(1'b1);
    exc_req <= 34'h1;
    bnd(1'b0);
    $display("test interrupts done");
    wr(trpv_pkg::A_TL, 32'h0);
    wr(trpv_pkg::A_CTRL, 32'h4);
    wr(trpv_pkg::A_FPSTAT, 32'h1);
    we_n = 1;
    fp(5'h02, 8'h5a);
    rd(trpv_pkg::A_FPSTAT, 32'h0001_6841);
    fp(5'h01, 8'hff);
    rd(trpv_pkg::A_FPSTAT, 32'h0001_6841);
    ex(1'b0, FP_CODE, trap_base_reg, 1'b0);
    bnd(1'b1);
    $display("test floating point done");
    wr(trpv_pkg::A_TL, 32'h0);
    wr(trpv_pkg::A_WIN, 32'h18);
    spill <= 1'b1;
    fill <= 1'b1;
    ex(1'b0, 9'h08c, trap_base_reg, 1'b0);
    bnd(1'b1);
    wr(trpv_pkg::A_WIN, 32'h159);
    fill <= 1'b1;
    ex(1'b0, 9'h0f4, trap_base_reg, 1'b1);
    bnd(1'b1);
    exc_req <= 34'h1;
    exc_hyper <= 34'h1;
    ex(1'b1, exc_tt[0], hba, 1'b1);
    bnd(1'b1);
    $display("test windows done");
    repeat (4) @(posedge clk);
    finish_test;
  end
endmodule // trpv_top_bench
`default_nettype wire
